// >>> hdl/port_cfg_pkg.sv
// shared constants and carriers for the per-port configuration word loader
// assumes a 16-bit word reader upstream and per-port config registers downstream
package port_cfg_pkg;

    // ---------------------------------------------------------------
    // word addresses in the nonvolatile image
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT2 = 8'h64;
    localparam logic [7:0] ADDR_PORT3 = 8'h66;
    localparam logic [7:0] ADDR_PORT4 = 8'h68;
    localparam int         NUM_PORTS  = 3;
    localparam logic [1:0] IDX_PORT2  = 2'h0;
    localparam logic [1:0] IDX_PORT3  = 2'h1;
    localparam logic [1:0] IDX_PORT4  = 2'h2;

    // ---------------------------------------------------------------
    // field positions inside the word
    // ---------------------------------------------------------------
    localparam int W_SLOT    = 0;
    localparam int W_CLK     = 1;
    localparam int W_DSI     = 2;
    localparam int W_LPC     = 3;
    localparam int W_PNUM_LO = 4;
    localparam int W_PNUM_HI = 6;
    localparam int W_TC_LO   = 9;
    localparam int W_TC_HI   = 15;

    // ---------------------------------------------------------------
    // target register offsets and bit positions
    // ---------------------------------------------------------------
    localparam logic [11:0] OFS_SLOT = 12'h0c0;
    localparam logic [11:0] OFS_CLK  = 12'h0d0;
    localparam logic [11:0] OFS_DSI  = 12'h040;
    localparam logic [11:0] OFS_LPC  = 12'h144;
    localparam logic [11:0] OFS_PNUM = 12'h0cc;
    localparam logic [11:0] OFS_TC   = 12'h154;
    localparam int R_SLOT    = 24;
    localparam int R_CLK     = 28;
    localparam int R_DSI     = 21;
    localparam int R_LPC     = 4;
    localparam int R_PNUM_LO = 24;
    localparam int R_PNUM_HI = 26;
    localparam int R_TC_LO   = 1;
    localparam int R_TC_HI   = 7;

    // ---------------------------------------------------------------
    // reset values of the loaded fields
    // ---------------------------------------------------------------
    localparam logic       RST_BIT  = 1'b0;
    localparam logic [2:0] RST_PNUM = 3'h0;
    localparam logic [6:0] RST_TC   = 7'h00;
    localparam int         FIFO_DEPTH = 4;

    // one word as it arrives from the reader
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } nv_word_t;

    // unpacked per-port fields
    typedef struct packed {
        logic       slot_impl;
        logic       slot_clk_cfg;
        logic       dsi_req;
        logic       low_priority_channel_group;
        logic [2:0] port_num;
        logic [6:0] tc_vc0_map;
    } port_fields_t;

endpackage : port_cfg_pkg

// >>> hdl/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous reset and a common clock enable
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("word_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // honest flags straight from the occupancy count
    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign push      = ce && in_valid && in_ready;
    assign pop       = ce && out_valid && out_ready;
    assign out_data  = mem[rd_reg];

    // storage, no reset needed on the data array
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_reg] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= wr_reg + AW'(1);
            if (pop)
                rd_reg <= rd_reg + AW'(1);
            if (push && !pop)
                cnt_reg <= cnt_reg + (AW+1)'(1);
            else if (pop && !push)
                cnt_reg <= cnt_reg - (AW+1)'(1);
        end
    end

    a_no_overflow: assert property (@(posedge clk) disable iff (srst)
        cnt_reg <= (AW+1)'(DEPTH))
        else $error("fifo accepts while full");
endmodule : word_fifo

// >>> hdl/port_config_word_loader.sv
// unpacks per-port configuration words for ports 2 to 4 into config bits
// assumes the nonvolatile reader hands words with their address, valid/ready,
// and that the switch core waits for load_done before host config access
`timescale 1ns/1ps

// How it works
// - bit 0 of the port word lands in bit 24 of that port's C0h register as slot implemented.
// - bit 1 lands in bit 28 of the port's D0h register as the connector clock selection.
// - bit 2 lands in bit 21 of the port's 40h register as device-specific init required.
// - bit 3 lands in bit 4 of the port's 144h register, putting VC1 in the low-priority group.
// - bits 6 to 4 land in bits 26 to 24 of the port's CCh register as the logical port number.
// - bits 15 to 9 land in bits 7 to 1 of the port's 154h register as the TC-to-VC0 map.
// - port 2 takes its word from address 64h with the same layout, ports 3 and 4 from 66h and 68h.
module port_config_word_loader #(
    parameter int DEPTH = port_cfg_pkg::FIFO_DEPTH
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        ce,
    input  wire port_cfg_pkg::nv_word_t      nv_word,
    input  wire logic                        nv_valid,
    output logic                             nv_ready,
    input  wire logic                        load_end,
    output logic                             load_done,
    output logic                             host_access_en,
    output port_cfg_pkg::port_fields_t       port2_fields,
    output port_cfg_pkg::port_fields_t       port3_fields,
    output port_cfg_pkg::port_fields_t       port4_fields,
    output logic [31:0]                      port2_c0,
    output logic [31:0]                      port3_c0,
    output logic [31:0]                      port4_c0
);
    localparam int WW = $bits(port_cfg_pkg::nv_word_t);

    initial
    begin
        if (DEPTH < 2)
            $error("loader fifo depth must be at least 2");
    end

    // ---------------------------------------------------------------
    // loader sequence
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {ST_LOAD, ST_DRAIN, ST_DONE} ld_state_t;

    ld_state_t                  state_reg;
    ld_state_t                  state_next;
    port_cfg_pkg::nv_word_t     q_word;
    logic                       q_valid;
    logic                       q_ready;
    logic                       fifo_in_ready;
    logic                       take;
    logic [1:0]                 port_idx;
    logic                       port_hit;
    port_cfg_pkg::port_fields_t dec;
    port_cfg_pkg::port_fields_t fields_reg [port_cfg_pkg::NUM_PORTS];

    // incoming words are buffered; once loading is over, further words are refused
    assign nv_ready = fifo_in_ready && (state_reg == ST_LOAD);

    word_fifo #(
        .WIDTH (WW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .in_data   (nv_word),
        .in_valid  (nv_valid && (state_reg == ST_LOAD)),
        .in_ready  (fifo_in_ready),
        .out_data  (q_word),
        .out_valid (q_valid),
        .out_ready (q_ready)
    );

    // the drain side never stalls: one word applied per enabled cycle
    assign q_ready = (state_reg != ST_DONE);
    assign take    = ce && q_valid && q_ready;

    // address decode of the three port words
    always_comb
    begin
        port_hit = 1'b1;
        port_idx = port_cfg_pkg::IDX_PORT2;
        case (q_word.addr)
            port_cfg_pkg::ADDR_PORT2: port_idx = port_cfg_pkg::IDX_PORT2;
            port_cfg_pkg::ADDR_PORT3: port_idx = port_cfg_pkg::IDX_PORT3;
            port_cfg_pkg::ADDR_PORT4: port_idx = port_cfg_pkg::IDX_PORT4;
            default:                  port_hit = 1'b0;
        endcase
    end

    // field extraction, identical layout for every port
    always_comb
    begin
        dec.slot_impl                  = q_word.data[port_cfg_pkg::W_SLOT];
        dec.slot_clk_cfg               = q_word.data[port_cfg_pkg::W_CLK];
        dec.dsi_req                    = q_word.data[port_cfg_pkg::W_DSI];
        dec.low_priority_channel_group = q_word.data[port_cfg_pkg::W_LPC];
        dec.port_num   = q_word.data[port_cfg_pkg::W_PNUM_HI:port_cfg_pkg::W_PNUM_LO];
        dec.tc_vc0_map = q_word.data[port_cfg_pkg::W_TC_HI:port_cfg_pkg::W_TC_LO];
    end

    // sequence: load until the reader says it is finished and the fifo is empty
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_LOAD:
            begin
                if (load_end)
                    state_next = ST_DRAIN;
            end
            ST_DRAIN:
            begin
                if (!q_valid)
                    state_next = ST_DONE;
            end
            ST_DONE:
                state_next = ST_DONE;
            default:
                state_next = ST_LOAD;
        endcase
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (srst)
            state_reg <= ST_LOAD;
        else if (ce)
            state_reg <= state_next;
    end

    // host access opens only after every buffered word is applied
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            load_done      <= 1'b0;
            host_access_en <= 1'b0;
        end
        else if (ce && state_reg == ST_DONE)
        begin
            load_done      <= 1'b1;
            host_access_en <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // per-port field storage
    // ---------------------------------------------------------------
    // unknown addresses are dropped; the other words belong to other loaders
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int i = 0; i < port_cfg_pkg::NUM_PORTS; i++)
            begin
                fields_reg[i].slot_impl                  <= port_cfg_pkg::RST_BIT;
                fields_reg[i].slot_clk_cfg               <= port_cfg_pkg::RST_BIT;
                fields_reg[i].dsi_req                    <= port_cfg_pkg::RST_BIT;
                fields_reg[i].low_priority_channel_group <= port_cfg_pkg::RST_BIT;
                fields_reg[i].port_num                   <= port_cfg_pkg::RST_PNUM;
                fields_reg[i].tc_vc0_map                 <= port_cfg_pkg::RST_TC;
            end
        end
        else if (take && port_hit)
            fields_reg[port_idx] <= dec;
    end

    assign port2_fields = fields_reg[port_cfg_pkg::IDX_PORT2];
    assign port3_fields = fields_reg[port_cfg_pkg::IDX_PORT3];
    assign port4_fields = fields_reg[port_cfg_pkg::IDX_PORT4];

    // ---------------------------------------------------------------
    // C0h view: only bit 24 is loaded, the rest stay at reset value zero
    // ---------------------------------------------------------------
    always_comb
    begin
        port2_c0 = '0;
        port3_c0 = '0;
        port4_c0 = '0;
        port2_c0[port_cfg_pkg::R_SLOT] = port2_fields.slot_impl;
        port3_c0[port_cfg_pkg::R_SLOT] = port3_fields.slot_impl;
        port4_c0[port_cfg_pkg::R_SLOT] = port4_fields.slot_impl;
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_port3_word;
        take && q_word.addr == port_cfg_pkg::ADDR_PORT3;
    endsequence

    sequence s_port4_word;
        take && q_word.addr == port_cfg_pkg::ADDR_PORT4;
    endsequence

    sequence s_port2_word;
        take && q_word.addr == port_cfg_pkg::ADDR_PORT2;
    endsequence

    a_slot_bit_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_c0[port_cfg_pkg::R_SLOT] == $past(q_word.data[port_cfg_pkg::W_SLOT]))
        else $error("port 3 slot bit not loaded");

    a_clk_bit_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_fields.slot_clk_cfg == $past(q_word.data[port_cfg_pkg::W_CLK]))
        else $error("port 4 clock bit not loaded");

    a_dsi_bit_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_fields.dsi_req == $past(q_word.data[port_cfg_pkg::W_DSI]))
        else $error("port 3 dsi bit not loaded");

    a_lpc_bit_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_fields.low_priority_channel_group == $past(q_word.data[port_cfg_pkg::W_LPC]))
        else $error("port 4 channel group bit not loaded");

    a_pnum_field_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_fields.port_num
            == $past(q_word.data[port_cfg_pkg::W_PNUM_HI:port_cfg_pkg::W_PNUM_LO]))
        else $error("port 3 port number not loaded");

    a_tc_map_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_fields.tc_vc0_map
            == $past(q_word.data[port_cfg_pkg::W_TC_HI:port_cfg_pkg::W_TC_LO]))
        else $error("port 4 tc map not loaded");

    a_port2_word: assert property (@(posedge clk) disable iff (srst)
        s_port2_word |=> port2_fields == $past(dec))
        else $error("port 2 word not applied");

    a_access_after_load: assert property (@(posedge clk) disable iff (srst)
        host_access_en |-> !q_valid && state_reg == ST_DONE)
        else $error("host access open while words pending");

    a_c0_other_bits: assert property (@(posedge clk) disable iff (srst)
        (port3_c0 & ~(32'h1 << port_cfg_pkg::R_SLOT)) == 32'h0)
        else $error("untouched c0 bits changed");

    a_fields_stable: assert property (@(posedge clk) disable iff (srst)
        (!take) |=> $stable(port2_fields) && $stable(port3_fields) && $stable(port4_fields))
        else $error("fields changed without a word");

    // ---------------------------------------------------------------
    // remaining fields, c0 images and sequencing
    // ---------------------------------------------------------------
    // each field is watched on both ports 3 and 4 so a swapped index cannot hide
    a_slot_bit_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_c0[port_cfg_pkg::R_SLOT] == $past(q_word.data[port_cfg_pkg::W_SLOT]))
        else $error("port 4 slot bit not loaded");

    a_clk_bit_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_fields.slot_clk_cfg == $past(q_word.data[port_cfg_pkg::W_CLK]))
        else $error("port 3 clock bit not loaded");

    a_dsi_bit_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_fields.dsi_req == $past(q_word.data[port_cfg_pkg::W_DSI]))
        else $error("port 4 dsi bit not loaded");

    a_lpc_bit_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_fields.low_priority_channel_group == $past(q_word.data[port_cfg_pkg::W_LPC]))
        else $error("port 3 channel group bit not loaded");

    a_pnum_field_p4: assert property (@(posedge clk) disable iff (srst)
        s_port4_word |=> port4_fields.port_num
            == $past(q_word.data[port_cfg_pkg::W_PNUM_HI:port_cfg_pkg::W_PNUM_LO]))
        else $error("port 4 port number not loaded");

    a_tc_map_p3: assert property (@(posedge clk) disable iff (srst)
        s_port3_word |=> port3_fields.tc_vc0_map
            == $past(q_word.data[port_cfg_pkg::W_TC_HI:port_cfg_pkg::W_TC_LO]))
        else $error("port 3 tc map not loaded");

    a_c0_bits_p2: assert property (@(posedge clk) disable iff (srst)
        (port2_c0 & ~(32'h1 << port_cfg_pkg::R_SLOT)) == 32'h0)
        else $error("untouched port 2 c0 bits changed");

    a_c0_bits_p4: assert property (@(posedge clk) disable iff (srst)
        (port4_c0 & ~(32'h1 << port_cfg_pkg::R_SLOT)) == 32'h0)
        else $error("untouched port 4 c0 bits changed");

    // a port 2 word must not spill into the neighbouring ports
    a_port_isolation: assert property (@(posedge clk) disable iff (srst)
        s_port2_word |=> $stable(port3_fields) && $stable(port4_fields))
        else $error("port 2 word touched another port");

    a_drop_unmapped: assert property (@(posedge clk) disable iff (srst)
        (take && !port_hit) |=> $stable(port2_fields) && $stable(port3_fields) && $stable(port4_fields))
        else $error("unmapped word changed a port");

    // completion: drain ends on empty, done follows, nothing arrives afterwards
    a_drain_ends: assert property (@(posedge clk) disable iff (srst)
        (ce && state_reg == ST_DRAIN && !q_valid) |=> state_reg == ST_DONE)
        else $error("drain did not end on empty fifo");

    a_done_timing: assert property (@(posedge clk) disable iff (srst)
        (ce && state_reg == ST_DONE) |=> load_done && host_access_en)
        else $error("load done late");

    a_done_sticky: assert property (@(posedge clk) disable iff (srst)
        load_done |=> load_done && host_access_en)
        else $error("load done dropped");

    a_no_word_after_done: assert property (@(posedge clk) disable iff (srst)
        (state_reg == ST_DONE) |=> !q_valid)
        else $error("word buffered after load done");

    // a low enable must hold the sequence where it is
    a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
        (!ce) |=> $stable(state_reg) && $stable(load_done))
        else $error("state moved while enable low");
endmodule : port_config_word_loader

// >>> sim/nv_reader_model.sv
// behavioural model of the nonvolatile word reader feeding the loader
// assumes the bench queues words through push and reads the accepted count
`timescale 1ns/1ps
module nv_reader_model (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    input  wire logic              nv_ready,
    output port_cfg_pkg::nv_word_t nv_word,
    output logic                   nv_valid
);
    // ---------------------------------------------------------------
    // word queue, gap before each word in idle cycles
    // ---------------------------------------------------------------
    port_cfg_pkg::nv_word_t q[$];
    int                     gap_q[$];
    int                     wait_cnt = 0;
    int                     accepted = 0;

    initial
    begin
        nv_valid = 1'b0;
        nv_word  = '0;
    end

    task automatic push(input port_cfg_pkg::nv_word_t w, input int gap);
        if (q.size() == 0)
            wait_cnt = 0;
        q.push_back(w);
        gap_q.push_back(gap);
    endtask : push

    // an offer holds until ready; idle data toggles so a stale word never looks fresh
    always @(posedge clk)
    begin
        if (srst)
        begin
            nv_valid <= 1'b0;
            q.delete();
            gap_q.delete();
        end
        else if (!nv_valid || (nv_ready && ce))
        begin
            if (nv_valid)
            begin
                void'(q.pop_front());
                accepted++;
            end
            if (q.size() != 0 && wait_cnt >= gap_q[0])
            begin
                nv_word  <= q[0];
                nv_valid <= 1'b1;
                void'(gap_q.pop_front());
                wait_cnt = 0;
            end
            else
            begin
                nv_valid <= 1'b0;
                nv_word  <= ~nv_word;
                wait_cnt++;
            end
        end
    end
endmodule : nv_reader_model

// >>> sim/port_config_word_loader_tb_top.sv
// self-checking bench for the per-port configuration word loader
// assumes the reader model and the design package are compiled first
`timescale 1ns/1ps
module port_config_word_loader_tb_top;
    // ---------------------------------------------------------------
    // clock, reset and wiring
    // ---------------------------------------------------------------
    logic                       clk = 1'b0;
    logic                       srst = 1'b1;
    logic                       ce = 1'b1;
    logic                       load_end = 1'b0;
    port_cfg_pkg::nv_word_t     nv_word;
    logic                       nv_valid, nv_ready, load_done, host_access_en;
    port_cfg_pkg::port_fields_t f2, f3, f4;
    logic [31:0]                c0_2, c0_3, c0_4;
    int                         miscompares = 0;
    int                         total_checks = 0;
    int                         cycles = 0;
    int                         n_acc = 0;

    always #5 clk = ~clk;

    port_config_word_loader #(.DEPTH(4)) DUT (
        .clk(clk), .srst(srst), .ce(ce), .nv_word(nv_word), .nv_valid(nv_valid),
        .nv_ready(nv_ready), .load_end(load_end), .load_done(load_done),
        .host_access_en(host_access_en), .port2_fields(f2), .port3_fields(f3),
        .port4_fields(f4), .port2_c0(c0_2), .port3_c0(c0_3), .port4_c0(c0_4)
    );

    nv_reader_model rdr (
        .clk(clk), .srst(srst), .ce(ce), .nv_ready(nv_ready), .nv_word(nv_word), .nv_valid(nv_valid)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // field set expected from a raw word, worked out bit by bit
    function automatic port_cfg_pkg::port_fields_t exp_f(input logic [15:0] d);
        return {d[0], d[1], d[2], d[3], d[6:4], d[15:9]};
    endfunction : exp_f

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : chk

    task automatic check_port(input int p, input logic [15:0] d);
        port_cfg_pkg::port_fields_t f;
        logic [31:0]                c;
        f = (p == 2) ? f2 : (p == 3) ? f3 : f4;
        c = (p == 2) ? c0_2 : (p == 3) ? c0_3 : c0_4;
        chk($sformatf("port%0d_fields", p), {18'h0, exp_f(d)}, {18'h0, f});
        chk($sformatf("port%0d_c0", p), {7'h0, d[0], 24'h0}, c);
    endtask : check_port

    task automatic send(input logic [7:0] a, input logic [15:0] d, input int gap);
        @(negedge clk);
        rdr.push({a, d}, gap);
        n_acc++;
    endtask : send

    // apply lands one edge after accept, so three edges leave margin for a queue
    task automatic settle();
        int k = 0;
        while (rdr.accepted < n_acc && k < 200)
        begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk);
        #1;
        chk("words accepted", n_acc, rdr.accepted);
    endtask : settle

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        for (int p = 2; p <= 4; p++)
            check_port(p, 16'h0000);
        chk("nv_ready", 1, nv_ready);
        chk("load_done", 0, load_done);
        chk("host_access_en", 0, host_access_en);
    endtask : t_reset

    // walking one catches swapped or shifted fields, bits 7 and 8 must land nowhere
    task automatic t_bits();
        for (int b = 0; b < 16; b++)
        begin
            send(port_cfg_pkg::ADDR_PORT3, 16'h0001 << b, 0);
            settle();
            check_port(3, 16'h0001 << b);
        end
        check_port(2, 16'h0000);
        check_port(4, 16'h0000);
    endtask : t_bits

    // back to back words with unmapped neighbours, then a slow overwrite
    task automatic t_ports();
        send(port_cfg_pkg::ADDR_PORT2, 16'h5a35, 0);
        send(8'h62, 16'hffff, 0);
        send(port_cfg_pkg::ADDR_PORT3, 16'ha6ca, 0);
        send(8'h6a, 16'hffff, 0);
        send(port_cfg_pkg::ADDR_PORT4, 16'h3c1e, 0);
        settle();
        check_port(2, 16'h5a35);
        check_port(3, 16'ha6ca);
        check_port(4, 16'h3c1e);
        send(port_cfg_pkg::ADDR_PORT4, 16'hc3e1, 5);
        settle();
        check_port(4, 16'hc3e1);
        check_port(2, 16'h5a35);
    endtask : t_ports

    // low enable freezes all: an offered word waits and a load_end pulse is ignored, then the word lands
    task automatic t_ce();
        @(posedge clk);
        ce <= 1'b0;
        load_end <= 1'b1;
        send(port_cfg_pkg::ADDR_PORT3, 16'h9e5b, 0);
        @(posedge clk);
        load_end <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk("words accepted", n_acc - 1, rdr.accepted);
        check_port(3, 16'ha6ca);
        chk("nv_ready", 1, nv_ready);
        @(posedge clk);
        ce <= 1'b1;
        settle();
        check_port(3, 16'h9e5b);
        chk("load_done", 0, load_done);
    endtask : t_ce

    // completion gates host access, later words refused, reset after completion clears all
    task automatic t_done();
        @(posedge clk);
        load_end <= 1'b1;
        @(posedge clk);
        load_end <= 1'b0;
        @(posedge clk);
        #1;
        chk("load_done", 0, load_done);
        @(posedge clk);
        #1;
        chk("load_done", 1, load_done);
        chk("host_access_en", 1, host_access_en);
        chk("nv_ready", 0, nv_ready);
        @(negedge clk);
        rdr.push({port_cfg_pkg::ADDR_PORT2, 16'hffff}, 0);
        repeat (10) @(posedge clk);
        #1;
        chk("words accepted", n_acc, rdr.accepted);
        check_port(2, 16'h5a35);
        chk("load_done", 1, load_done);
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
    endtask : t_done

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // the whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_bits();
        t_ports();
        t_ce();
        t_done();
        give_verdict();
    end
endmodule : port_config_word_loader_tb_top
